// ---- xcl_consts.svh ----
// Offsets, field positions, reset values and timing counts of the X.21 clocking block
`ifndef XCL_CONSTS_SVH
`define XCL_CONSTS_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define XCL_OFS_CTRL   8'h00
`define XCL_OFS_STAT   8'h04
`define XCL_OFS_CLR    8'h08
`define XCL_OFS_EN     8'h0c
`define XCL_OFS_STATE  8'h10
// -----------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------
`define XCL_CTRL_W     9
`define XCL_B_DTE      0
`define XCL_B_RS422    1
`define XCL_TXC_LSB    2
`define XCL_RXC_LSB    4
`define XCL_B_RTS      6
`define XCL_B_ALM_SV   7
`define XCL_B_ALM_DTR  8
`define XCL_CTRL_RST   9'h000
// -----------------------------------------------------------------
// Event bits
// -----------------------------------------------------------------
`define XCL_EV_W       3
`define XCL_EV_MARG    0
`define XCL_EV_SV      1
`define XCL_EV_DTR     2
`define XCL_EV_RST     3'h0
// -----------------------------------------------------------------
// Pin indices
// -----------------------------------------------------------------
`define XCL_NPIN       6
`define XCL_PIN_SAT    0
`define XCL_PIN_STN    1
`define XCL_PIN_TERM   2
`define XCL_PIN_TXD    3
`define XCL_PIN_SV     4
`define XCL_PIN_DTR    5
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define XCL_CLK_NS       25
`define XCL_INT_HALF_NS  500
`define XCL_INT_HALF_CYC ((`XCL_INT_HALF_NS + `XCL_CLK_NS - 1) / `XCL_CLK_NS)
`define XCL_ERR_LIMIT    4
`endif

// ---- xcl_pkg.sv ----
// Types of the X.21 clocking block
package xcl_pkg;
  typedef enum logic [1:0] {XCL_TXC_INT, XCL_TXC_RX, XCL_TXC_TXIN, XCL_TXC_RSV} xcl_txc_t;
  typedef enum logic [1:0] {XCL_RXC_SAT, XCL_RXC_INT, XCL_RXC_STN, XCL_RXC_TXIN} xcl_rxc_t;
  typedef enum logic {XCL_PH_RISE, XCL_PH_FALL} xcl_phase_t;
endpackage

// ---- xcl_phase_sel.sv ----
// Automatic sampling-phase selector for incoming serial data
`timescale 1ns/100ps
`default_nettype none
`include "xcl_consts.svh"
module xcl_phase_sel #(
  parameter int unsigned ERR_LIMIT = `XCL_ERR_LIMIT
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              data,
  input  wire logic              rise_stb,
  input  wire logic              fall_stb,
  output var  logic              bit_out,
  output var  logic              bit_stb,
  output var  xcl_pkg::xcl_phase_t phase,
  output var  logic              marginal
);
  import xcl_pkg::*;

  localparam logic [3:0] LIM_M1 = 4'(ERR_LIMIT - 1);

  logic       data_d;
  logic [3:0] cnt;
  logic       strobe;
  logic       unstable;
  logic       next_data_d;
  logic [3:0] next_cnt;
  xcl_phase_t next_phase;
  logic       next_bit;
  logic       next_stb;
  logic       next_marg;

  // -----------------------------------------------------------------
  // Phase decision
  // -----------------------------------------------------------------
  // A sample is unstable when the data moved in the cycle of the edge
  always_comb begin
    strobe      = enable && ((phase == XCL_PH_RISE) ? rise_stb : fall_stb);
    unstable    = data != data_d;
    next_data_d = data;
    next_cnt    = cnt;
    next_phase  = phase;
    next_bit    = bit_out;
    next_stb    = 1'b0;
    next_marg   = 1'b0;
    if (!enable) begin
      next_cnt = 4'h0;
    end else if (strobe) begin
      next_bit = data_d;
      next_stb = 1'b1;
      if (!unstable) begin
        next_cnt = 4'h0;
      end else if (cnt == LIM_M1) begin
        next_cnt   = 4'h0;
        next_phase = (phase == XCL_PH_RISE) ? XCL_PH_FALL : XCL_PH_RISE;
        next_marg  = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_d   <= 1'b0;
      cnt      <= 4'h0;
      phase    <= XCL_PH_RISE;
      bit_out  <= 1'b0;
      bit_stb  <= 1'b0;
      marginal <= 1'b0;
    end else begin
      data_d   <= next_data_d;
      cnt      <= next_cnt;
      phase    <= next_phase;
      bit_out  <= next_bit;
      bit_stb  <= next_stb;
      marginal <= next_marg;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  AST_PH_SWITCH_WARN: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(phase) |-> marginal)
    else $error("phase changed without marginal warning");
  AST_PH_NEEDS_REPEAT: assert property (@(posedge mclk) disable iff (!rst_n)
    marginal |-> $past(cnt) == LIM_M1 && $past(unstable) && $past(strobe))
    else $error("phase switched before repeated errors");
  CVR_PH_SWITCH: cover property (@(posedge mclk) disable iff (!rst_n) marginal);
endmodule // xcl_phase_sel
`default_nettype wire

// ---- xcl_top.sv ----
// X.21 DCE/DTE terrestrial clock selection, data sampling and carrier control
// Operation
// - DCE drives one clock out: satellite, internal oscillator or station clock.
// - DCE never uses external tx clock; tx data sampled on the outgoing clock.
// - DTE takes the only clock from terrestrial side for both directions.
// - Sampling phase chosen automatically; every switch raises a marginal warning.
// - DCE measures tx data phase against the clock it sends out.
// - DTE measures tx data phase against the terrestrial clock received.
// - With RTS control, transmit carrier follows the incoming signal-valid line.
// - Optional alarms when signal-valid or terminal-ready go inactive.
// - X.21 runs only in RS422 mode with matching tx and rx clocking.
`timescale 1ns/100ps
`default_nettype none
`include "xcl_consts.svh"
module xcl_top #(
  parameter int unsigned INT_HALF  = `XCL_INT_HALF_CYC,
  parameter int unsigned ERR_LIMIT = `XCL_ERR_LIMIT
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sat_clk_in,
  input  wire logic        stn_clk_in,
  input  wire logic        term_clk_in,
  input  wire logic        tx_data_in,
  input  wire logic        sig_valid_in,
  input  wire logic        dte_ready_in,
  input  wire logic        rx_bit,
  output var  logic        rx_bit_take,
  output var  logic        clk_out,
  output var  logic        clk_out_oe,
  output var  logic        rx_data_out,
  output var  logic        rx_data_oe,
  output var  logic        carrier_on,
  output var  logic        tx_bit,
  output var  logic        tx_bit_stb,
  output var  logic        irq
);
  import xcl_pkg::*;

  localparam logic [15:0] HALF_M1 = 16'(INT_HALF - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [`XCL_NPIN-1:0] pin_raw;
  logic [`XCL_NPIN-1:0] pin_m;
  logic [`XCL_NPIN-1:0] pin_s;
  logic [`XCL_NPIN-1:0] pin_d;

  assign pin_raw = {dte_ready_in, sig_valid_in, tx_data_in, term_clk_in, stn_clk_in, sat_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < `XCL_NPIN; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pin_m[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
          pin_d[gi] <= 1'b0;
        end else begin
          pin_m[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_m[gi];
          pin_d[gi] <= pin_s[gi];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------
  logic [`XCL_CTRL_W-1:0] ctrl;
  logic [`XCL_EV_W-1:0]   stat;
  logic [`XCL_EV_W-1:0]   en;
  logic [`XCL_CTRL_W-1:0] next_ctrl;
  logic [`XCL_EV_W-1:0]   next_stat;
  logic [`XCL_EV_W-1:0]   next_en;
  logic [31:0]            next_prdata;
  logic                   next_pready;
  logic                   next_pslverr;
  logic                   next_irq;
  logic                   acc;
  logic                   mapped;
  logic [`XCL_EV_W-1:0]   ev;
  logic [`XCL_EV_W-1:0]   clr;
  logic [5:0]             live;

  xcl_txc_t txc_m;
  xcl_rxc_t rxc_m;
  logic     dte_m;
  logic     rts_m;
  logic     x21_ok;

  always_comb begin
    dte_m = ctrl[`XCL_B_DTE];
    rts_m = ctrl[`XCL_B_RTS];
    txc_m = xcl_txc_t'(ctrl[`XCL_TXC_LSB +: 2]);
    rxc_m = xcl_rxc_t'(ctrl[`XCL_RXC_LSB +: 2]);
    // External tx clock is never a source in DCE
    if (!ctrl[`XCL_B_RS422]) begin
      x21_ok = 1'b0;
    end else if (dte_m) begin
      x21_ok = (txc_m == XCL_TXC_TXIN) && (rxc_m == XCL_RXC_TXIN);
    end else begin
      x21_ok = (txc_m == XCL_TXC_RX) && (rxc_m != XCL_RXC_TXIN);
    end
  end

  logic ph_marg;
  logic sv_fall;
  logic dtr_fall;
  xcl_phase_t phase;

  // Inactive is the low level on both lines
  assign sv_fall  = pin_d[`XCL_PIN_SV] & ~pin_s[`XCL_PIN_SV] & ctrl[`XCL_B_ALM_SV];
  assign dtr_fall = pin_d[`XCL_PIN_DTR] & ~pin_s[`XCL_PIN_DTR] & ctrl[`XCL_B_ALM_DTR];

  always_comb begin
    acc    = psel && penable && pready;
    mapped = hit(paddr, `XCL_OFS_CTRL) || hit(paddr, `XCL_OFS_STAT) || hit(paddr, `XCL_OFS_CLR)
          || hit(paddr, `XCL_OFS_EN) || hit(paddr, `XCL_OFS_STATE);
    ev = '0;
    ev[`XCL_EV_MARG] = ph_marg;
    ev[`XCL_EV_SV]   = sv_fall && x21_ok;
    ev[`XCL_EV_DTR]  = dtr_fall && x21_ok;
    clr = (acc && pwrite && hit(paddr, `XCL_OFS_CLR)) ? pwdata[`XCL_EV_W-1:0] : '0;
    live = {~dte_m, pin_s[`XCL_PIN_DTR], pin_s[`XCL_PIN_SV], carrier_on, phase == XCL_PH_FALL, x21_ok};
    next_ctrl = ctrl;
    next_en   = en;
    if (acc && pwrite && hit(paddr, `XCL_OFS_CTRL)) begin
      next_ctrl = pwdata[`XCL_CTRL_W-1:0];
    end
    if (acc && pwrite && hit(paddr, `XCL_OFS_EN)) begin
      next_en = pwdata[`XCL_EV_W-1:0];
    end
    // A new event beats a clear in the same cycle
    next_stat    = (stat & ~clr) | ev;
    next_irq     = |(next_stat & next_en);
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    next_prdata  = 32'h0000_0000;
    if (next_pready && !pwrite) begin
      if (hit(paddr, `XCL_OFS_CTRL)) begin
        next_prdata = {{(32-`XCL_CTRL_W){1'b0}}, ctrl};
      end else if (hit(paddr, `XCL_OFS_STAT)) begin
        next_prdata = {{(32-`XCL_EV_W){1'b0}}, stat};
      end else if (hit(paddr, `XCL_OFS_EN)) begin
        next_prdata = {{(32-`XCL_EV_W){1'b0}}, en};
      end else if (hit(paddr, `XCL_OFS_STATE)) begin
        next_prdata = {26'h0, live};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `XCL_CTRL_RST;
      stat    <= `XCL_EV_RST;
      en      <= `XCL_EV_RST;
      irq     <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      ctrl    <= next_ctrl;
      stat    <= next_stat;
      en      <= next_en;
      irq     <= next_irq;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // -----------------------------------------------------------------
  // Internal oscillator divider
  // -----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic        int_clk;
  logic [15:0] next_div_cnt;
  logic        next_int_clk;

  always_comb begin
    next_div_cnt = div_cnt + 16'h0001;
    next_int_clk = int_clk;
    if (div_cnt == HALF_M1) begin
      next_div_cnt = 16'h0000;
      next_int_clk = ~int_clk;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      int_clk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      int_clk <= next_int_clk;
    end
  end

  // -----------------------------------------------------------------
  // Reference clock and link timing
  // -----------------------------------------------------------------
  logic ref_lvl;
  logic ref_d;
  logic ref_rise;
  logic ref_fall;
  logic next_clk_out;
  logic next_clk_oe;
  logic next_rxd;
  logic next_rxd_oe;
  logic next_take;
  logic next_carrier;

  // In DCE the reference is the clock that leaves the port one mclk later, so tx data phase is
  // judged against what the far end sees, apart from that register stage and pad delay
  always_comb begin
    if (dte_m) begin
      ref_lvl = pin_s[`XCL_PIN_TERM];
    end else begin
      case (rxc_m)
        XCL_RXC_SAT: ref_lvl = pin_s[`XCL_PIN_SAT];
        XCL_RXC_INT: ref_lvl = int_clk;
        XCL_RXC_STN: ref_lvl = pin_s[`XCL_PIN_STN];
        default:     ref_lvl = 1'b0;
      endcase
    end
    if (!x21_ok) begin
      ref_lvl = 1'b0;
    end
    ref_rise     = ref_lvl & ~ref_d;
    ref_fall     = ~ref_lvl & ref_d;
    next_clk_oe  = x21_ok && !dte_m;
    next_clk_out = next_clk_oe && ref_lvl;
    next_rxd_oe  = x21_ok;
    next_rxd     = rx_data_out;
    next_take    = 1'b0;
    // Rx data launched on the falling edge, half a period before sampling
    if (x21_ok && ref_fall) begin
      next_rxd  = rx_bit;
      next_take = 1'b1;
    end
    if (!x21_ok) begin
      next_rxd = 1'b0;
    end
    next_carrier = x21_ok && (!rts_m || pin_s[`XCL_PIN_SV]);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d       <= 1'b0;
      clk_out     <= 1'b0;
      clk_out_oe  <= 1'b0;
      rx_data_out <= 1'b0;
      rx_data_oe  <= 1'b0;
      rx_bit_take <= 1'b0;
      carrier_on  <= 1'b0;
    end else begin
      ref_d       <= ref_lvl;
      clk_out     <= next_clk_out;
      clk_out_oe  <= next_clk_oe;
      rx_data_out <= next_rxd;
      rx_data_oe  <= next_rxd_oe;
      rx_bit_take <= next_take;
      carrier_on  <= next_carrier;
    end
  end

  // -----------------------------------------------------------------
  // Tx data sampling
  // -----------------------------------------------------------------
  xcl_phase_sel #(
    .ERR_LIMIT (ERR_LIMIT)
  ) u_phase (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .enable   (x21_ok),
    .data     (pin_s[`XCL_PIN_TXD]),
    .rise_stb (ref_rise),
    .fall_stb (ref_fall),
    .bit_out  (tx_bit),
    .bit_stb  (tx_bit_stb),
    .phase    (phase),
    .marginal (ph_marg)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_CLK_ONE_SRC: assert property (
    x21_ok && !dte_m && rxc_m == XCL_RXC_SAT |=> clk_out_oe && clk_out == $past(pin_s[`XCL_PIN_SAT]))
    else $error("clock out does not follow satellite source");
  AST_DCE_NO_TXIN: assert property (
    !dte_m && (txc_m == XCL_TXC_TXIN || rxc_m == XCL_RXC_TXIN) |-> !x21_ok)
    else $error("external tx clock accepted in DCE");
  AST_DTE_NO_CLKOUT: assert property (
    dte_m |=> !clk_out_oe && !clk_out)
    else $error("clock driven out in DTE operation");
  AST_RX_ON_FALL: assert property (
    rx_bit_take |-> $past(ref_fall) && $past(x21_ok))
    else $error("rx data launched off the falling edge");
  AST_MARG_STICKY: assert property (
    ph_marg |=> stat[`XCL_EV_MARG])
    else $error("phase switch not flagged");
  AST_DCE_SAMPLE_OUT: assert property (
    x21_ok && !dte_m && ref_rise |=> clk_out && !$past(clk_out))
    else $error("tx sampling edge is not the outgoing clock edge");
  AST_DTE_REF_TERM: assert property (
    x21_ok && dte_m |-> ref_lvl == pin_s[`XCL_PIN_TERM])
    else $error("DTE reference is not the terrestrial clock");
  AST_CARRIER_RTS: assert property (
    x21_ok && rts_m ##1 x21_ok && rts_m |-> carrier_on == $past(pin_s[`XCL_PIN_SV]))
    else $error("carrier does not follow signal valid");
  AST_SV_ALARM: assert property (
    x21_ok && sv_fall |=> stat[`XCL_EV_SV])
    else $error("signal valid alarm missing");
  AST_X21_GATE: assert property (
    !ctrl[`XCL_B_RS422] |=> !clk_out_oe && !rx_data_oe && !carrier_on)
    else $error("port active outside RS422 mode");
  AST_IRQ_LEVEL: assert property (
    irq == |(stat & en))
    else $error("interrupt without enabled status");

  CVR_DCE_TX: cover property (x21_ok && !dte_m && tx_bit_stb);
  CVR_DTE_TX: cover property (x21_ok && dte_m && tx_bit_stb);
  CVR_MARG_IRQ: cover property (ph_marg ##1 irq);
  CVR_SV_ALARM: cover property (x21_ok && sv_fall);
endmodule // xcl_top
`default_nettype wire

// ---- xcl_term_model.sv ----
// Behavioural terrestrial equipment on the far side of the X.21 port
`timescale 1ns/100ps
`default_nettype none
module xcl_term_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic dte_mode,
  input  wire logic run,
  input  wire logic bad_skew,
  input  wire logic dev_clk,
  output var  logic term_clk,
  output var  logic tx_data
);
  logic [3:0] pat;
  wire        ref_clk = dte_mode ? term_clk : dev_clk;
  // Only clock in DTE; it stands still low outside runs
  initial begin
    term_clk = 1'b0;
    forever begin
      #HALF_NS;
      term_clk = run & dte_mode & ~term_clk;
    end
  end
  // Skewed mode moves data on the sampling edge to provoke errors;
  // normal mode launches data on the fall, half a period from sampling
  initial begin
    pat     = 4'h9;
    tx_data = 1'b0;
    forever begin
      @(ref_clk);
      if (bad_skew && ref_clk) begin
        tx_data <= ~tx_data;
      end else if (!bad_skew && !ref_clk) begin
        pat     <= {pat[2:0], pat[3] ^ pat[2]};
        tx_data <= pat[3];
      end
    end
  end
endmodule // xcl_term_model
`default_nettype wire

// ---- tb_x21_terrestrial_clocking.sv ----
// Self-checking bench for the X.21 clocking block
`timescale 1ns/100ps
`default_nettype none
module tb_x21_terrestrial_clocking;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sat_clk_in, stn_clk_in, term_clk_in, tx_data_in, sig_valid_in, dte_ready_in, rx_bit;
  logic        rx_bit_take, clk_out, clk_out_oe, rx_data_out, rx_data_oe, carrier_on, tx_bit, tx_bit_stb, irq;
  logic        dte_mode, run, bad_skew, er;
  int          bad_count, checks_done, cyc;

  xcl_top #(.ERR_LIMIT(2)) i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sat_clk_in(sat_clk_in),
    .stn_clk_in(stn_clk_in), .term_clk_in(term_clk_in), .tx_data_in(tx_data_in), .sig_valid_in(sig_valid_in),
    .dte_ready_in(dte_ready_in), .rx_bit(rx_bit), .rx_bit_take(rx_bit_take), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe), .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .carrier_on(carrier_on),
    .tx_bit(tx_bit), .tx_bit_stb(tx_bit_stb), .irq(irq));
  xcl_term_model i_far (.dte_mode(dte_mode), .run(run), .bad_skew(bad_skew), .dev_clk(clk_out),
    .term_clk(term_clk_in), .tx_data(tx_data_in));

  initial begin
    mclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sat_clk_in = 0;
    stn_clk_in = 0; sig_valid_in = 1; dte_ready_in = 1; rx_bit = 0; dte_mode = 0; run = 0; bad_skew = 0;
    bad_count = 0; checks_done = 0; cyc = 0;
  end
  always #12.5 mclk = ~mclk;
  always #100 sat_clk_in = ~sat_clk_in;
  always #150 stn_clk_in = ~stn_clk_in;
  always @(posedge mclk) if (rx_bit_take === 1'b1) rx_bit <= ~rx_bit;
  // Whole run needs a few hundred cycles; this ceiling only catches hangs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic wait_stb();
    @(posedge mclk);
    while (tx_bit_stb !== 1'b1) begin
      @(posedge mclk);
    end
  endtask
  // Returns one edge after the take pulse, before rx_bit moves on
  task automatic wait_take();
    @(posedge mclk);
    while (rx_bit_take !== 1'b1) begin
      @(posedge mclk);
    end
  endtask

  task automatic t_regs();
    rdchk(8'h00, 32'hffffffff, 32'h0);
    rdchk(8'h04, 32'hffffffff, 32'h0);
    rdchk(8'h0c, 32'hffffffff, 32'h0);
    rdchk(8'h10, 32'h1, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    wr(8'h00, 32'h004);
    rdchk(8'h10, 32'h1, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_dce();
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h006 | (i << 4));
      rdchk(8'h10, 32'h21, 32'h21);
      @(posedge clk_out);
      @(posedge mclk);
      chk(clk_out_oe, 1'b1);
    end
    wr(8'h00, 32'h006);
    repeat (3) begin
      @(posedge sat_clk_in);
      @(posedge mclk);
      repeat (5) @(posedge mclk);
      chk({clk_out_oe, clk_out}, 32'h3);
      wait_stb();
      chk(tx_bit, tx_data_in);
      wait_take();
      chk({clk_out, rx_data_out}, {1'b0, rx_bit});
    end
    wr(8'h00, 32'h00a);
    repeat (3) @(posedge mclk);
    chk(clk_out_oe, 1'b0);
    $display("test dce done");
  endtask
  task automatic t_carrier();
    wr(8'h00, 32'h046);
    sig_valid_in <= 0;
    repeat (6) @(posedge mclk);
    chk(carrier_on, 1'b0);
    sig_valid_in <= 1;
    repeat (6) @(posedge mclk);
    chk(carrier_on, 1'b1);
    $display("test carrier done");
  endtask
  task automatic t_alarm();
    wr(8'h00, 32'h186);
    wr(8'h08, 32'h7);
    wr(8'h0c, 32'h6);
    dte_ready_in <= 0;
    repeat (6) @(posedge mclk);
    rdchk(8'h04, 32'h7, 32'h4);
    chk(irq, 1'b1);
    wr(8'h0c, 32'h2);
    chk(irq, 1'b0);
    wr(8'h08, 32'h4);
    rdchk(8'h04, 32'h7, 32'h0);
    dte_ready_in <= 1;
    sig_valid_in <= 0;
    repeat (6) @(posedge mclk);
    chk(irq, 1'b1);
    sig_valid_in <= 1;
    wr(8'h08, 32'h2);
    chk(irq, 1'b0);
    $display("test alarm done");
  endtask
  task automatic t_dte();
    dte_mode <= 1;
    run <= 1;
    wr(8'h00, 32'h03b);
    rdchk(8'h10, 32'h21, 32'h01);
    repeat (4) begin
      wait_stb();
      chk(tx_bit, tx_data_in);
    end
    wait_take();
    chk(rx_data_out, rx_bit);
    chk({clk_out_oe, rx_data_oe}, 32'h1);
    wr(8'h00, 32'h01b);
    rdchk(8'h10, 32'h1, 32'h0);
    $display("test dte done");
  endtask
  task automatic t_phase();
    wr(8'h00, 32'h03b);
    wr(8'h08, 32'h7);
    wr(8'h0c, 32'h1);
    bad_skew <= 1;
    while (irq !== 1'b1) begin
      @(posedge mclk);
    end
    rdchk(8'h04, 32'h1, 32'h1);
    rdchk(8'h10, 32'h2, 32'h2);
    $display("test phase done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    t_regs();
    t_dce();
    t_carrier();
    t_alarm();
    t_dte();
    t_phase();
    end_of_test();
  end
endmodule // tb_x21_terrestrial_clocking
`default_nettype wire
